// ===== rtl/spm_clkdiv.sv
// Programmable divider giving a tick every DIV cycles and a toggled clock
`timescale 1ns/1ps
module spm_clkdiv #(
   parameter int W = 8
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_ce,
   input  wire logic         i_run,
   input  wire logic [W-1:0] i_div,
   output logic              o_tick,
   output logic              o_clk
);

   logic [W-1:0] cnt_r;
   logic         tick_r;
   logic         clk_r;

   wire          active = i_run && (i_div != '0);
   wire          wrap   = cnt_r >= (i_div - W'(1));

   // Zero divisor is reserved: divider clears to zero and stays stopped
   always_ff @(posedge i_clk) begin
      if (i_rst || (i_ce && !active)) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
         clk_r  <= 1'b0;
      end else if (i_ce) begin
         cnt_r  <= wrap ? '0 : cnt_r + W'(1);
         tick_r <= wrap;
         clk_r  <= wrap ? ~clk_r : clk_r;
      end
   end

   assign o_tick = tick_r;
   assign o_clk  = clk_r;

endmodule // spm_clkdiv

// ===== rtl/spm_pkg.sv
// Register map, field layouts and carriers for the serial port mode control
package spm_pkg;

   localparam logic [7:0]  ADR_MODE_CTRL = 8'h14;
   localparam logic [7:0]  ADR_GUARD_PSC = 8'h18;
   localparam logic [7:0]  ADR_SYNC_CFG  = 8'h1c;
   localparam logic [7:0]  ADR_IRQ_STAT  = 8'h20;
   localparam logic [7:0]  ADR_IRQ_MASK  = 8'h24;

   localparam logic [10:0] MODE_RST      = 11'h000;
   localparam logic [15:0] GTP_RST       = 16'h0000;
   localparam logic [10:0] SYNC_RST      = 11'h000;
   localparam logic [2:0]  IRQ_RST       = 3'h0;

   // Sticky status bit positions
   localparam int          ST_CTS        = 0;
   localparam int          ST_ERR        = 1;
   localparam int          ST_TXC        = 2;
   localparam int          ST_W          = 3;

   localparam int          MUTE_BIT      = 5;
   localparam logic [7:0]  GUARD_ONE     = 8'h01;

   typedef struct packed {
      logic cts_change_irq_en;
      logic cts_flow_en;
      logic rts_flow_en;
      logic dma_tx_en_a;
      logic dma_rx_en_b;
      logic smartcard_en;
      logic smartcard_nack_en;
      logic half_duplex_en;
      logic infrared_low_power;
      logic infrared_en;
      logic error_irq_en;
   } spm_mode_t;

   typedef struct packed {
      logic [7:0] guard_time_value;
      logic [7:0] clock_prescale_value;
   } spm_gtp_t;

   typedef struct packed {
      logic       sync_clock_polarity;
      logic       sync_clock_phase;
      logic       last_bit_pulse_out;
      logic [1:0] unused;
      logic       mute;
      logic       wake_method_select;
      logic [3:0] node_address;
   } spm_sync_t;

   typedef struct packed {
      logic       valid;
      logic [8:0] frame;
      logic       idle;
      logic       parity_err;
      logic       framing_err;
      logic       overrun_err;
      logic       noise_err;
   } spm_rx_evt_t;

endpackage

// ===== rtl/spm_sync2.sv
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module spm_sync2 #(
   parameter logic RST_VAL = 1'b1
) (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_ce,
   input  wire logic i_d,
   output logic      o_q
);

   logic meta_r;
   logic q_r;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_r <= RST_VAL;
         q_r    <= RST_VAL;
      end else if (i_ce) begin
         meta_r <= i_d;
         q_r    <= meta_r;
      end
   end

   assign o_q = q_r;

endmodule // spm_sync2

// ===== rtl/spm_top.sv
// Serial port mode control: registers, wake, flow control, guard, clocks
//
// Summary of operation
// - Address wake mutes on a low-nibble mismatch and wakes on a match.
// - With its enable and mask bit 0 set, a clear-to-send change raises the interrupt.
// - Bit 9 enables clear-to-send flow control of the transmitter.
// - Bit 8 enables request-to-send flow control driven by the receiver.
// - Bit 7 enables DMA transmit service and bit 6 DMA receive service.
// - Bit 5 selects smartcard operation.
// - In smartcard mode with bit 4 set, a parity error triggers a NACK.
// - Bit 3 selects half-duplex single-line operation.
// - Bit 1 enables infrared; bit 2 picks prescaled low-power pulses.
// - With DMA receive, bit 0 and mask bit 1, framing, overrun or noise interrupt.
// - In smartcard mode transmit complete waits guard time baud clocks.
// - Low-power infrared divides the clock by 1 to 255; zero is reserved.
// - The card clock is the clock divided by twice prescaler bits 4:0.
// - Wake method zero wakes on an idle frame and one on an address match.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module spm_top
   import spm_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   input  wire logic        i_ce,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic        i_cts_n,
   input  wire spm_rx_evt_t i_rx_evt,
   input  wire logic        i_rx_ready,
   input  wire logic        i_tx_enabled,
   input  wire logic        i_tx_frame_done,
   input  wire logic        i_baud_tick,
   output spm_mode_t        o_mode,
   output spm_sync_t        o_sync,
   output logic             o_irq,
   output logic             o_mute,
   output logic             o_tx_start_ok,
   output logic             o_rts_n,
   output logic             o_nack_req,
   output logic             o_tx_complete,
   output logic             o_ir_lp_tick,
   output logic             o_sc_clk
);

   spm_mode_t        mode_r;
   spm_mode_t        mode_nxt;
   spm_gtp_t         gtp_r;
   spm_gtp_t         gtp_nxt;
   spm_sync_t        sync_r;
   spm_sync_t        sync_nxt;
   logic             mute_r;
   logic             mute_nxt;
   logic [ST_W-1:0]  stat_r;
   logic [ST_W-1:0]  stat_nxt;
   logic [ST_W-1:0]  mask_r;
   logic [ST_W-1:0]  mask_nxt;
   logic             irq_r;
   logic             ack_r;
   logic [31:0]      rdat_r;
   logic             cts_s;
   logic             cts_d_r;
   logic             ok_r;
   logic             rts_n_r;
   logic             nack_r;
   logic             txc_r;
   logic             guard_busy_r;
   logic             guard_busy_nxt;
   logic [7:0]       guard_cnt_r;
   logic [7:0]       guard_cnt_nxt;

   function automatic logic [15:0] merge(input logic [15:0] old_v,
                                         input logic [15:0] m,
                                         input logic [15:0] d);
      return (old_v & ~m) | (d & m);
   endfunction

   // Bus decode
   wire        wb_req   = i_wb_cyc && i_wb_stb && !ack_r;
   wire        wb_wr    = wb_req && i_wb_we;
   wire        wb_rd    = wb_req && !i_wb_we;
   wire        hit_mode = i_wb_adr == ADR_MODE_CTRL;
   wire        hit_gtp  = i_wb_adr == ADR_GUARD_PSC;
   wire        hit_sync = i_wb_adr == ADR_SYNC_CFG;
   wire        hit_stat = i_wb_adr == ADR_IRQ_STAT;
   wire        hit_mask = i_wb_adr == ADR_IRQ_MASK;
   wire [15:0] be_mask  = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
   wire [15:0] wdat     = i_wb_dat[15:0];

   wire [15:0] mode_wr  = merge({5'h00, mode_r}, be_mask, wdat);
   wire [15:0] gtp_wr   = merge(gtp_r, be_mask, wdat);
   wire [15:0] sync_wr  = merge({5'h00, sync_r}, be_mask, wdat);
   wire [15:0] mask_wr  = merge({13'h0000, mask_r}, be_mask, wdat);

   assign mode_nxt = (wb_wr && hit_mode) ? mode_wr[10:0] : mode_r;
   assign gtp_nxt  = (wb_wr && hit_gtp) ? gtp_wr : gtp_r;
   assign mask_nxt = (wb_wr && hit_mask) ? mask_wr[ST_W-1:0] : mask_r;

   // Clock shape bits frozen while the transmitter runs
   wire        sync_lock = i_tx_enabled;
   wire [10:0] sync_cand = (wb_wr && hit_sync) ? sync_wr[10:0] : sync_r;
   assign sync_nxt = sync_lock ?
                     {sync_r[10:8], 2'b00, 1'b0, sync_cand[4:0]} :
                     {sync_cand[10:8], 2'b00, 1'b0, sync_cand[4:0]};

   // Mute control; receiver events win over a software write
   wire addr_mode  = sync_r.wake_method_select;
   wire addr_match = i_rx_evt.frame[3:0] == sync_r.node_address;
   wire sw_mute    = wb_wr && hit_sync && i_wb_sel[0];
   always_comb begin
      mute_nxt = mute_r;
      if (sw_mute) begin
         mute_nxt = wdat[MUTE_BIT];
      end
      if (addr_mode && i_rx_evt.valid) begin
         mute_nxt = !addr_match;
      end else if (!addr_mode && i_rx_evt.idle) begin
         mute_nxt = 1'b0;
      end
   end

   // Clear-to-send pin
   spm_sync2 #(
      .RST_VAL (1'b1)
   ) u_cts_sync (
      .i_clk (i_ref_clk),
      .i_rst (i_rst),
      .i_ce  (i_ce),
      .i_d   (i_cts_n),
      .o_q   (cts_s)
   );

   wire cts_edge = cts_s ^ cts_d_r;

   // Smartcard guard time before transmit complete
   wire sc_guard   = mode_r.smartcard_en &&
                     (gtp_r.guard_time_value != 8'h00);
   wire guard_done = guard_busy_r && i_baud_tick &&
                     (guard_cnt_r == GUARD_ONE);
   wire guard_arm  = i_tx_frame_done && sc_guard;
   wire txc_evt    = (i_tx_frame_done && !sc_guard) || guard_done;

   always_comb begin
      guard_busy_nxt = guard_busy_r;
      guard_cnt_nxt  = guard_cnt_r;
      if (guard_arm) begin
         guard_busy_nxt = 1'b1;
         guard_cnt_nxt  = gtp_r.guard_time_value;
      end else if (guard_done) begin
         guard_busy_nxt = 1'b0;
      end else if (guard_busy_r && i_baud_tick) begin
         guard_cnt_nxt  = guard_cnt_r - 8'h01;
      end
   end

   // Interrupt events; set wins over read clear
   wire err_any = i_rx_evt.framing_err || i_rx_evt.overrun_err ||
                  i_rx_evt.noise_err;
   wire err_evt = mode_r.dma_rx_en_b && mode_r.error_irq_en &&
                  err_any;
   wire [ST_W-1:0] ev_vec = {txc_evt, err_evt, cts_edge};
   wire [ST_W-1:0] en_vec = {2'b11, mode_r.cts_change_irq_en};
   wire            rd_clr = wb_rd && hit_stat;
   assign stat_nxt = (rd_clr ? IRQ_RST : stat_r) | ev_vec;

   // Handshake and mode outputs
   wire ok_nxt   = !mode_r.cts_flow_en || !cts_s;
   wire rts_nxt  = mode_r.rts_flow_en && !i_rx_ready;
   wire nack_nxt = mode_r.smartcard_en && mode_r.smartcard_nack_en &&
                   i_rx_evt.valid && i_rx_evt.parity_err;

   // Read data
   wire [31:0] rd_mux =
      hit_mode ? {21'h000000, mode_r} :
      hit_gtp  ? {16'h0000, gtp_r} :
      hit_sync ? {21'h000000, sync_r[10:6], mute_r, sync_r[4:0]} :
      hit_stat ? {29'h00000000, stat_r} :
      hit_mask ? {29'h00000000, mask_r} :
      32'h00000000;

   // Prescaled clocks
   wire ir_run = mode_r.infrared_en && mode_r.infrared_low_power;
   wire [7:0] sc_div = {3'h0, gtp_r.clock_prescale_value[4:0]};

   spm_clkdiv #(
      .W (8)
   ) u_ir_div (
      .i_clk  (i_ref_clk),
      .i_rst  (i_rst),
      .i_ce   (i_ce),
      .i_run  (ir_run),
      .i_div  (gtp_r.clock_prescale_value),
      .o_tick (o_ir_lp_tick),
      .o_clk  ()
   );

   spm_clkdiv #(
      .W (8)
   ) u_sc_div (
      .i_clk  (i_ref_clk),
      .i_rst  (i_rst),
      .i_ce   (i_ce),
      .i_run  (mode_r.smartcard_en),
      .i_div  (sc_div),
      .o_tick (),
      .o_clk  (o_sc_clk)
   );

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         mode_r <= MODE_RST;
         gtp_r  <= GTP_RST;
         sync_r <= SYNC_RST;
         mute_r <= 1'b0;
         stat_r <= IRQ_RST;
         mask_r <= IRQ_RST;
      end else if (i_ce) begin
         mode_r <= mode_nxt;
         gtp_r  <= gtp_nxt;
         sync_r <= sync_nxt;
         mute_r <= mute_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h00000000;
         irq_r  <= 1'b0;
      end else if (i_ce) begin
         ack_r  <= wb_req;
         rdat_r <= wb_rd ? rd_mux : rdat_r;
         irq_r  <= |(stat_r & mask_r & en_vec);
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         cts_d_r      <= 1'b1;
         ok_r         <= 1'b0;
         rts_n_r      <= 1'b0;
         nack_r       <= 1'b0;
         txc_r        <= 1'b0;
         guard_busy_r <= 1'b0;
         guard_cnt_r  <= 8'h00;
      end else if (i_ce) begin
         cts_d_r      <= cts_s;
         ok_r         <= ok_nxt;
         rts_n_r      <= rts_nxt;
         nack_r       <= nack_nxt;
         txc_r        <= txc_evt;
         guard_busy_r <= guard_busy_nxt;
         guard_cnt_r  <= guard_cnt_nxt;
      end
   end

   assign o_wb_dat      = rdat_r;
   assign o_wb_ack      = ack_r;
   assign o_mode        = mode_r;
   assign o_sync        = {sync_r[10:6], mute_r, sync_r[4:0]};
   assign o_irq         = irq_r;
   assign o_mute        = mute_r;
   assign o_tx_start_ok = ok_r;
   assign o_rts_n       = rts_n_r;
   assign o_nack_req    = nack_r;
   assign o_tx_complete = txc_r;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   a_addr_mute: assert property (
      (i_ce && addr_mode && i_rx_evt.valid && !addr_match) |=> o_mute)
      else $error("address mismatch did not mute");
   a_addr_wake: assert property (
      (i_ce && addr_mode && i_rx_evt.valid && addr_match) |=> !o_mute)
      else $error("address match did not wake");
   a_idle_wake: assert property (
      (i_ce && !addr_mode && i_rx_evt.idle) |=> !o_mute)
      else $error("idle frame did not wake");
   a_cts_gate: assert property (
      (i_ce && mode_r.cts_flow_en && cts_s) |=> !o_tx_start_ok)
      else $error("frame start allowed with clear-to-send high");
   a_rts_level: assert property (
      (i_ce && mode_r.rts_flow_en && !i_rx_ready) |=> o_rts_n)
      else $error("request-to-send not released");
   a_nack_pulse: assert property (
      (i_ce && mode_r.smartcard_en && mode_r.smartcard_nack_en &&
       i_rx_evt.valid && i_rx_evt.parity_err) |=> o_nack_req)
      else $error("parity error gave no nack");
   a_err_flag: assert property (
      (i_ce && mode_r.dma_rx_en_b && mode_r.error_irq_en &&
       i_rx_evt.framing_err) |=> stat_r[ST_ERR])
      else $error("receive error not flagged");
   a_cts_flag: assert property (
      (i_ce && (cts_s != cts_d_r)) |=> stat_r[ST_CTS])
      else $error("clear-to-send change not flagged");
   a_txc_direct: assert property (
      (i_ce && i_tx_frame_done && !mode_r.smartcard_en) |=> o_tx_complete)
      else $error("transmit complete not immediate");
   a_guard_hold: assert property (
      (i_ce && i_tx_frame_done && sc_guard) |=> !o_tx_complete)
      else $error("guard time not applied");
   a_ack_single: assert property (
      o_wb_ack |=> !o_wb_ack)
      else $error("ack held too long");

   c_nack:  cover property (o_nack_req);
   c_wake:  cover property (o_mute ##1 !o_mute);
   c_guard: cover property (guard_busy_r ##1 o_tx_complete);
   c_irq:   cover property (o_irq);

endmodule // spm_top

// ===== testbench/spm_far_node.sv
// Far-side model: remote node receive events, clear-to-send, baud ticks
`timescale 1ns/1ps
module spm_far_node
   import spm_pkg::*;
#(
   parameter int BAUD_DIV = 4
) (
   input  wire logic   i_clk,
   output spm_rx_evt_t o_rx_evt,
   output logic        o_cts_n,
   output logic        o_frame_done,
   output logic        o_baud_tick
);
   int cnt_r = 0;
   initial begin
      o_rx_evt     = '0;
      o_cts_n      = 1'b1;
      o_frame_done = 1'b0;
   end
   always @(posedge i_clk) begin
      cnt_r       <= (cnt_r == BAUD_DIV - 1) ? 0 : cnt_r + 1;
      o_baud_tick <= (cnt_r == BAUD_DIV - 1);
   end
   // Frame field shows junk once the event has passed
   task automatic rx(input logic [8:0] f, input logic [3:0] e,
                     input logic idl);
      @(posedge i_clk);
      o_rx_evt <= {~idl, f, idl, e};
      @(posedge i_clk);
      o_rx_evt <= {1'b0, ~f, 5'h00};
   endtask
   task automatic cts(input logic v);
      @(posedge i_clk);
      o_cts_n <= v;
   endtask
   // Frame end just after a baud tick keeps the guard count exact
   task automatic tx_done();
      int n;
      @(posedge i_clk);
      for (n = 0; n < 50 && o_baud_tick !== 1'b1; n++)
         @(posedge i_clk);
      o_frame_done <= 1'b1;
      @(posedge i_clk);
      o_frame_done <= 1'b0;
   endtask
endmodule // spm_far_node

// ===== testbench/test_serial_port_mode_control.sv
// Self-checking bench for the serial port mode control block
`timescale 1ns/1ps
module test_serial_port_mode_control;
   import spm_pkg::*;
   localparam int BAUD = 4;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0;
   logic        we = 1'b0, rx_ready = 1'b1, tx_en = 1'b0, ce = 1'b1;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat;
   logic        ack, cts_n, done, btick, irq, mute, start_ok, rts_n;
   logic        nack, tx_complete_flag, irt, scc;
   spm_rx_evt_t rx_evt;
   spm_mode_t   mode;
   spm_sync_t   sync;
   int          bad_count = 0;
   int          cmp_count = 0;

   always #25 clk = ~clk;

   spm_top spm_top_inst (
      .i_ref_clk(clk), .i_rst(rst), .i_ce(ce), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_cts_n(cts_n),
      .i_rx_evt(rx_evt), .i_rx_ready(rx_ready), .i_tx_enabled(tx_en),
      .i_tx_frame_done(done), .i_baud_tick(btick), .o_mode(mode),
      .o_sync(sync), .o_irq(irq), .o_mute(mute), .o_tx_start_ok(start_ok),
      .o_rts_n(rts_n), .o_nack_req(nack), .o_tx_complete(tx_complete_flag),
      .o_ir_lp_tick(irt), .o_sc_clk(scc)
   );
   spm_far_node #(.BAUD_DIV(BAUD)) spm_far_node_inst (
      .i_clk(clk), .o_rx_evt(rx_evt), .o_cts_n(cts_n),
      .o_frame_done(done), .o_baud_tick(btick)
   );

   task automatic print_verdict();
      if (bad_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e,
                      input string m);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [3:0] s, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= s;
      wdat <= d;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (ack === 1'b1)
            break;
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n == 20) begin
         bad_count++;
         print_verdict();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, 4'hf, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input string m);
      logic [31:0] q;
      xfer(a, 1'b0, 4'hf, 32'h0, q);
      chk(q, e, m);
   endtask
   // 0 nack, 1 irq, 2 tx complete, 3 ir tick, 4 card clock, 5 mute,
   // 6 start allowed, 7 rts
   function automatic logic probe(input int k);
      case (k)
         0: return nack;
         1: return irq;
         2: return tx_complete_flag;
         3: return irt;
         4: return scc;
         5: return mute;
         6: return start_ok;
         default: return rts_n;
      endcase
   endfunction
   task automatic lvl(input int k, input logic e, input string m);
      repeat (6) @(posedge clk);
      chk({31'h0, probe(k)}, {31'h0, e}, m);
   endtask
   task automatic hits(input int k, input int len, input int e,
                       input string m);
      int n;
      int c;
      c = 0;
      for (n = 0; n < len; n++) begin
         @(posedge clk);
         c += (probe(k) === 1'b1);
      end
      chk(32'(c), 32'(e), m);
   endtask
   // Cycles between two rising edges of a probe
   task automatic meas(input int k, input int e, input string m);
      int n;
      int t0;
      int per;
      int r;
      logic prv;
      r = 0;
      per = -1;
      prv = 1'b1;
      for (n = 0; n < 700 && r < 2; n++) begin
         @(posedge clk);
         if (probe(k) === 1'b1 && prv === 1'b0) begin
            r++;
            if (r == 1)
               t0 = n;
            else
               per = n - t0;
         end
         prv = probe(k);
      end
      chk(32'(per), 32'(e), m);
   endtask
   task automatic gcase(input logic [31:0] md, input int g);
      int n;
      wr(ADR_MODE_CTRL, md);
      wr(ADR_GUARD_PSC, {16'h0, 8'(g), 8'h01});
      spm_far_node_inst.tx_done();
      for (n = 1; n < 1100; n++) begin
         @(posedge clk);
         if (tx_complete_flag === 1'b1)
            break;
      end
      chk(32'(n), (md[5] && g > 0) ? 32'(BAUD * g) : 32'h1, "guard");
   endtask

   task automatic t_regs();
      logic [31:0] q;
      int i;
      rd(ADR_MODE_CTRL, 32'h0, "mode rst");
      rd(ADR_GUARD_PSC, 32'h0, "gtp rst");
      rd(ADR_SYNC_CFG, 32'h0, "sync rst");
      rd(ADR_IRQ_MASK, 32'h0, "mask rst");
      for (i = 0; i < 11; i++) begin
         wr(ADR_MODE_CTRL, 32'h1 << i);
         rd(ADR_MODE_CTRL, 32'h1 << i, "mode");
         chk({21'h0, mode}, 32'h1 << i, "mode out");
      end
      xfer(ADR_GUARD_PSC, 1'b1, 4'h2, 32'hffff_abcd, q);
      rd(ADR_GUARD_PSC, 32'h0000_ab00, "gtp sel");
      wr(8'h30, 32'hffff_ffff);
      rd(8'h30, 32'h0, "unmapped");
      wr(ADR_MODE_CTRL, 32'h100);
      rx_ready <= 1'b0;
      lvl(7, 1'b1, "rts stop");
      rx_ready <= 1'b1;
      lvl(7, 1'b0, "rts go");
      rx_ready <= 1'b0;
      wr(ADR_MODE_CTRL, 32'h0);
      lvl(7, 1'b0, "rts off");
      rx_ready <= 1'b1;
   endtask
   task automatic t_cts();
      wr(ADR_IRQ_MASK, 32'h1);
      wr(ADR_MODE_CTRL, 32'h200);
      lvl(6, 1'b0, "cts hold");
      spm_far_node_inst.cts(1'b0);
      lvl(6, 1'b1, "cts go");
      lvl(1, 1'b0, "cts irq off");
      rd(ADR_IRQ_STAT, 32'h1, "cts flag");
      wr(ADR_MODE_CTRL, 32'h600);
      spm_far_node_inst.cts(1'b1);
      lvl(1, 1'b1, "cts irq");
      lvl(6, 1'b0, "cts stop");
      rd(ADR_IRQ_STAT, 32'h1, "cts flag2");
      lvl(1, 1'b0, "irq clr");
      wr(ADR_IRQ_MASK, 32'h0);
      spm_far_node_inst.cts(1'b0);
      lvl(1, 1'b0, "masked");
      rd(ADR_IRQ_STAT, 32'h1, "cts flag3");
      wr(ADR_MODE_CTRL, 32'h0);
   endtask
   task automatic t_err();
      int i;
      wr(ADR_IRQ_MASK, 32'h2);
      wr(ADR_MODE_CTRL, 32'h41);
      for (i = 0; i < 3; i++) begin
         spm_far_node_inst.rx(9'h0, 4'h1 << i, 1'b0);
         lvl(1, 1'b1, "err irq");
         rd(ADR_IRQ_STAT, 32'h2, "err flag");
      end
      spm_far_node_inst.rx(9'h0, 4'h8, 1'b0);
      rd(ADR_IRQ_STAT, 32'h0, "parity only");
      wr(ADR_MODE_CTRL, 32'h1);
      spm_far_node_inst.rx(9'h0, 4'h4, 1'b0);
      lvl(1, 1'b0, "no dma");
      for (i = 0; i < 3; i++) begin
         wr(ADR_MODE_CTRL, i == 1 ? 32'h20 : 32'h30);
         spm_far_node_inst.rx(9'h55, i == 2 ? 4'h0 : 4'h8, 1'b0);
         hits(0, 4, i == 0, "nack");
      end
   endtask
   task automatic t_clk();
      gcase(32'h0, 5);
      gcase(32'h20, 0);
      gcase(32'h20, 1);
      gcase(32'h20, 3);
      gcase(32'h20, 255);
      wr(ADR_GUARD_PSC, 32'h1);
      wr(ADR_MODE_CTRL, 32'h2);
      hits(3, 20, 0, "ir normal");
      wr(ADR_MODE_CTRL, 32'h6);
      repeat (4) @(posedge clk);
      hits(3, 10, 10, "lp div 1");
      wr(ADR_GUARD_PSC, 32'h3);
      meas(3, 3, "lp div 3");
      wr(ADR_GUARD_PSC, 32'hff);
      meas(3, 255, "lp div 255");
      wr(ADR_MODE_CTRL, 32'h20);
      meas(4, 62, "sc div 62");
      wr(ADR_GUARD_PSC, 32'h2);
      meas(4, 4, "sc div 4");
      wr(ADR_MODE_CTRL, 32'h0);
   endtask
   task automatic t_wake();
      wr(ADR_SYNC_CFG, 32'h1a);
      spm_far_node_inst.rx(9'h0a5, 4'h0, 1'b0);
      lvl(5, 1'b1, "addr miss");
      rd(ADR_SYNC_CFG, 32'h3a, "live mute");
      spm_far_node_inst.rx(9'h0, 4'h0, 1'b1);
      lvl(5, 1'b1, "idle in addr");
      spm_far_node_inst.rx(9'h13a, 4'h0, 1'b0);
      lvl(5, 1'b0, "addr hit");
      wr(ADR_SYNC_CFG, 32'h20);
      spm_far_node_inst.rx(9'h0a0, 4'h0, 1'b0);
      lvl(5, 1'b1, "no compare");
      ce <= 1'b0;
      spm_far_node_inst.rx(9'h0, 4'h0, 1'b1);
      lvl(5, 1'b1, "frozen");
      ce <= 1'b1;
      spm_far_node_inst.rx(9'h0, 4'h0, 1'b1);
      lvl(5, 1'b0, "idle wake");
      tx_en <= 1'b1;
      wr(ADR_SYNC_CFG, 32'h70f);
      rd(ADR_SYNC_CFG, 32'h00f, "locked");
      tx_en <= 1'b0;
      wr(ADR_SYNC_CFG, 32'h700);
      rd(ADR_SYNC_CFG, 32'h700, "unlocked");
      chk({21'h0, sync}, 32'h700, "sync out");
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_cts();
      t_err();
      t_clk();
      t_wake();
      print_verdict();
   end
endmodule // test_serial_port_mode_control
